/* hw/rsp_pkg.sv */
package rsp_pkg;
  localparam int DATA_W = 32;
  localparam logic [19:0] IO_PAGE = 20'h00000;
  localparam logic [19:0] OWN_PAGE = 20'h00001;
  localparam logic [1:0] STAT_IDX = 2'h0;
  localparam logic [1:0] MASK_IDX = 2'h1;
  localparam logic [2:0] DIR_OFS = 3'h7;
  localparam logic [2:0] WIN_ZERO = 3'h0;
  localparam int DIR_RX = 0;
  localparam int DIR_TX = 1;
  localparam logic [1:0] DIR_RESET = 2'h0;
  localparam logic [1:0] DIR_BOTH = 2'h3;
  localparam logic [9:0] BASE_COM1 = 10'h3F8;
  localparam logic [9:0] BASE_COM2 = 10'h2F8;
  localparam logic [9:0] BASE_COM3 = 10'h3E8;
  localparam logic [9:0] BASE_COM4 = 10'h2E8;
  localparam logic [6:0] SW_COM1 = 7'h00;
  localparam logic [6:0] SW_COM2 = 7'h20;
  localparam logic [6:0] SW_COM3 = 7'h02;
  localparam logic [6:0] SW_COM4 = 7'h22;
  localparam int STAT_W = 3;
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_DIR = 2;
  localparam logic [2:0] STAT_RESET = 3'h0;
  localparam logic [2:0] U_DATA = 3'h0;
  localparam logic [2:0] U_IER = 3'h1;
  localparam logic [2:0] U_IIR = 3'h2;
  localparam logic [2:0] U_LCR = 3'h3;
  localparam logic [2:0] U_MCR = 3'h4;
  localparam logic [2:0] U_LSR = 3'h5;
  localparam logic [2:0] U_MSR = 3'h6;
  localparam int LCR_DLAB = 7;
  localparam int MCR_OUT2 = 3;
  localparam logic [7:0] IIR_NONE = 8'h01;
  localparam logic [7:0] IIR_THRE = 8'h02;
  localparam logic [7:0] IIR_RDA = 8'h04;
  localparam logic [3:0] OVS_PAD = 4'h0;
  localparam logic [3:0] START_BIT = 4'h0;
  localparam logic [3:0] STOP_BIT = 4'h9;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_ACC = 2'b10} rsp_state_t;
  typedef enum logic [2:0] {
    T_NONE, T_UART, T_DIR, T_STAT, T_MASK
  } rsp_target_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] ofs;
    logic [7:0] wdata;
  } rsp_io_req_t;
endpackage : rsp_pkg

/* hw/rsp_uart.sv */
`timescale 1ns/1ps
module rsp_uart (
  input wire logic hclk,
  input wire logic hresetn,
  input wire rsp_pkg::rsp_io_req_t req,
  input wire logic rxd,
  output logic [7:0] rdata,
  output logic txd,
  output logic intr,
  output logic rx_done,
  output logic tx_done
);
  logic [7:0] dll_q, dlm_q, lcr_q, thr_q, rbr_q, rx_sh_q, iir;
  logic [3:0] ier_q, tx_bits_q, rx_bits_q;
  logic [4:0] mcr_q;
  logic [9:0] tx_sh_q;
  logic [19:0] bit_len, half_len, rx_tgt, tx_cnt_q, rx_cnt_q;
  logic thr_full_q, tx_busy_q, rx_busy_q, dr_q, oe_q, dlab, data_rd;

  // Fixed 8N1 framing; line control only steers the divisor latch
  assign dlab = lcr_q[rsp_pkg::LCR_DLAB];
  assign bit_len = {dlm_q, dll_q, rsp_pkg::OVS_PAD};
  assign half_len = {1'b0, bit_len[19:1]};
  assign rx_tgt = (rx_bits_q == rsp_pkg::START_BIT) ? half_len : bit_len;
  assign txd = tx_sh_q[0];
  assign data_rd = req.rd && req.ofs == rsp_pkg::U_DATA && !dlab;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dll_q <= rsp_pkg::DIV_RESET[7:0];
      dlm_q <= rsp_pkg::DIV_RESET[15:8];
      ier_q <= '0;
      lcr_q <= '0;
      mcr_q <= '0;
    end else if (req.wr) begin
      case (req.ofs)
        rsp_pkg::U_DATA: if (dlab) dll_q <= req.wdata;
        rsp_pkg::U_IER: begin
          if (dlab) dlm_q <= req.wdata;
          else ier_q <= req.wdata[3:0];
        end
        rsp_pkg::U_LCR: lcr_q <= req.wdata;
        rsp_pkg::U_MCR: mcr_q <= req.wdata[4:0];
        default: ;
      endcase
    end
  end

  // A write in the load cycle lands after the load, so it is kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sh_q <= '1;
      tx_busy_q <= 1'b0;
      tx_bits_q <= '0;
      tx_cnt_q <= '0;
      thr_q <= '0;
      thr_full_q <= 1'b0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (!tx_busy_q) begin
        if (thr_full_q) begin
          tx_sh_q <= {1'b1, thr_q, 1'b0};
          tx_busy_q <= 1'b1;
          thr_full_q <= 1'b0;
          tx_cnt_q <= '0;
          tx_bits_q <= '0;
        end
      end else if (tx_cnt_q == bit_len - 20'h1) begin
        tx_cnt_q <= '0;
        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
        tx_bits_q <= tx_bits_q + 4'h1;
        if (tx_bits_q == rsp_pkg::STOP_BIT) begin
          tx_busy_q <= 1'b0;
          tx_done <= 1'b1;
        end
      end else begin
        tx_cnt_q <= tx_cnt_q + 20'h1;
      end
      if (req.wr && req.ofs == rsp_pkg::U_DATA && !dlab) begin
        thr_q <= req.wdata;
        thr_full_q <= 1'b1;
      end
    end
  end

  // A byte landing on the cycle its flag is read still sets the flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_bits_q <= '0;
      rx_sh_q <= '0;
      rbr_q <= '0;
      dr_q <= 1'b0;
      oe_q <= 1'b0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (data_rd) dr_q <= 1'b0;
      if (req.rd && req.ofs == rsp_pkg::U_LSR) oe_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rxd) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= '0;
          rx_bits_q <= '0;
        end
      end else if (rx_cnt_q == rx_tgt - 20'h1) begin
        rx_cnt_q <= '0;
        rx_bits_q <= rx_bits_q + 4'h1;
        if (rx_bits_q == rsp_pkg::START_BIT) begin
          if (rxd) rx_busy_q <= 1'b0;
        end else if (rx_bits_q == rsp_pkg::STOP_BIT) begin
          rx_busy_q <= 1'b0;
          rbr_q <= rx_sh_q;
          dr_q <= 1'b1;
          // Overrun stays sticky until the status read clears it
          if (dr_q && !data_rd) oe_q <= 1'b1;
          rx_done <= 1'b1;
        end else begin
          rx_sh_q <= {rxd, rx_sh_q[7:1]};
        end
      end else begin
        rx_cnt_q <= rx_cnt_q + 20'h1;
      end
    end
  end

  assign iir = (ier_q[0] && dr_q) ? rsp_pkg::IIR_RDA :
               (ier_q[1] && !thr_full_q) ? rsp_pkg::IIR_THRE :
               rsp_pkg::IIR_NONE;

  // OUT2 gates the interrupt line, as PC serial drivers expect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) intr <= 1'b0;
    else intr <= mcr_q[rsp_pkg::MCR_OUT2] && iir != rsp_pkg::IIR_NONE;
  end

  always_comb begin
    case (req.ofs)
      rsp_pkg::U_DATA: rdata = dlab ? dll_q : rbr_q;
      rsp_pkg::U_IER: rdata = dlab ? dlm_q : {4'h0, ier_q};
      rsp_pkg::U_IIR: rdata = iir;
      rsp_pkg::U_LCR: rdata = lcr_q;
      rsp_pkg::U_MCR: rdata = {3'h0, mcr_q};
      rsp_pkg::U_LSR: rdata = {1'b0, !tx_busy_q && !thr_full_q,
                               !thr_full_q, 3'h0, oe_q, dr_q};
      default: rdata = 8'h00;
    endcase
  end
endmodule : rsp_uart

/* hw/rsp_top.sv */
`timescale 1ns/1ps
module rsp_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [6:0] base_switch_up,
  input wire logic irq_jumper,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe_n,
  output logic line_transmit_enable,
  output logic line_receive_enable,
  output logic irq_level4,
  output logic irq_level3,
  output logic irq
);
  rsp_pkg::rsp_state_t st_q;
  rsp_pkg::rsp_target_t tgt_q;
  rsp_pkg::rsp_io_req_t ureq;
  logic [6:0] sw_s1_q, sw_s2_q;
  logic jmp_s1_q, jmp_s2_q, lin_s1_q, lin_s2_q;
  logic [9:0] win_base;
  logic [2:0] ofs_q;
  logic wr_q, take, acc;
  logic [1:0] dir_q;
  logic dir_seen_q;
  logic [rsp_pkg::STAT_W-1:0] stat_q, mask_q, events;
  logic [7:0] uart_rdata;
  logic uart_txd, uart_intr, rx_done, tx_done, rxd_int;
  logic dir_wr, stat_rd;

  // Every transfer gets one wait state so read data leaves a flip-flop
  function automatic rsp_pkg::rsp_target_t decode(
    input logic [31:0] a,
    input logic [9:0] base
  );
    rsp_pkg::rsp_target_t t;
    t = rsp_pkg::T_NONE;
    if (a[31:12] == rsp_pkg::IO_PAGE && a[11:5] == base[9:3]) begin
      if (a[4:2] == rsp_pkg::DIR_OFS) t = rsp_pkg::T_DIR;
      else t = rsp_pkg::T_UART;
    end else if (a[31:12] == rsp_pkg::OWN_PAGE && a[11:4] == 8'h00) begin
      case (a[3:2])
        rsp_pkg::STAT_IDX: t = rsp_pkg::T_STAT;
        rsp_pkg::MASK_IDX: t = rsp_pkg::T_MASK;
        default: t = rsp_pkg::T_NONE;
      endcase
    end
    return t;
  endfunction : decode

  // Switches, jumper and line pin come from outside the clock domain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_s1_q <= '0;
      sw_s2_q <= '0;
      jmp_s1_q <= 1'b0;
      jmp_s2_q <= 1'b0;
      lin_s1_q <= 1'b1;
      lin_s2_q <= 1'b1;
    end else begin
      sw_s1_q <= base_switch_up;
      sw_s2_q <= sw_s1_q;
      jmp_s1_q <= irq_jumper;
      jmp_s2_q <= jmp_s1_q;
      lin_s1_q <= line_in;
      lin_s2_q <= lin_s1_q;
    end
  end

  // A switch up clears the address bit it stands for
  assign win_base = {~sw_s2_q, rsp_pkg::WIN_ZERO};

  assign take = hsel && htrans[1] && hready;
  assign acc = (st_q == rsp_pkg::ST_ACC);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= rsp_pkg::ST_IDLE;
      hreadyout <= 1'b1;
      tgt_q <= rsp_pkg::T_NONE;
      wr_q <= 1'b0;
      ofs_q <= '0;
    end else begin
      case (st_q)
        rsp_pkg::ST_IDLE: begin
          if (take) begin
            st_q <= rsp_pkg::ST_ACC;
            hreadyout <= 1'b0;
            tgt_q <= decode(haddr, win_base);
            wr_q <= hwrite;
            ofs_q <= haddr[4:2];
          end
        end
        rsp_pkg::ST_ACC: begin
          st_q <= rsp_pkg::ST_IDLE;
          hreadyout <= 1'b1;
        end
        default: begin
          st_q <= rsp_pkg::ST_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hresp <= 1'b0;
    else hresp <= 1'b0;
  end

  // Offsets zero to six go to the serial controller untouched
  always_comb begin
    ureq.wr = acc && wr_q && tgt_q == rsp_pkg::T_UART;
    ureq.rd = acc && !wr_q && tgt_q == rsp_pkg::T_UART;
    ureq.ofs = ofs_q;
    ureq.wdata = hwdata[7:0];
  end

  assign dir_wr = acc && wr_q && tgt_q == rsp_pkg::T_DIR;
  assign stat_rd = acc && !wr_q && tgt_q == rsp_pkg::T_STAT;

  // Only a write at offset seven moves the direction; reads are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_q <= rsp_pkg::DIR_RESET;
      line_oe_n <= 1'b1;
      line_transmit_enable <= 1'b0;
      line_receive_enable <= 1'b0;
    end else if (dir_wr) begin
      dir_q <= hwdata[1:0];
      line_oe_n <= !hwdata[rsp_pkg::DIR_TX];
      line_transmit_enable <= hwdata[rsp_pkg::DIR_TX];
      line_receive_enable <= hwdata[rsp_pkg::DIR_RX];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) dir_seen_q <= 1'b0;
    else if (dir_wr) dir_seen_q <= 1'b1;
  end

  // Receiver off reads idle; with both on the controller hears itself
  always_comb begin
    if (!dir_q[rsp_pkg::DIR_RX]) rxd_int = 1'b1;
    else if (dir_q[rsp_pkg::DIR_TX]) rxd_int = uart_txd;
    else rxd_int = lin_s2_q;
  end

  rsp_uart u_uart (
    .hclk(hclk),
    .hresetn(hresetn),
    .req(ureq),
    .rxd(rxd_int),
    .rdata(uart_rdata),
    .txd(uart_txd),
    .intr(uart_intr),
    .rx_done(rx_done),
    .tx_done(tx_done)
  );

  // The line pin always follows the shifter; the enable decides who hears it
  assign line_out = uart_txd;

  // Jumper low selects level 4, high selects level 3
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_level4 <= 1'b0;
      irq_level3 <= 1'b0;
    end else begin
      irq_level4 <= uart_intr && !jmp_s2_q;
      irq_level3 <= uart_intr && jmp_s2_q;
    end
  end

  always_comb begin
    events = '0;
    events[rsp_pkg::EV_RX] = rx_done;
    events[rsp_pkg::EV_TX] = tx_done;
    events[rsp_pkg::EV_DIR] = dir_wr;
  end

  // An event in the clearing read cycle survives the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) stat_q <= rsp_pkg::STAT_RESET;
    else if (stat_rd) stat_q <= events;
    else stat_q <= stat_q | events;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) mask_q <= rsp_pkg::STAT_RESET;
    else if (acc && wr_q && tgt_q == rsp_pkg::T_MASK)
      mask_q <= hwdata[rsp_pkg::STAT_W-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq <= 1'b0;
    else irq <= |(stat_q & mask_q);
  end

  // Write-only and unmapped words read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= '0;
    else if (acc && !wr_q) begin
      case (tgt_q)
        rsp_pkg::T_UART: hrdata <= {24'h000000, uart_rdata};
        rsp_pkg::T_STAT: hrdata <= {29'h00000000, stat_q};
        rsp_pkg::T_MASK: hrdata <= {29'h00000000, mask_q};
        default: hrdata <= '0;
      endcase
    end else if (acc) hrdata <= '0;
  end

  a_dir_reset_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !dir_seen_q |-> (dir_q == rsp_pkg::DIR_RESET && line_oe_n &&
                     !line_receive_enable))
    else $error("line enabled before any direction write");

  a_dir_write_take: assert property (
    @(posedge hclk) disable iff (!hresetn)
    dir_wr |=> (dir_q == $past(hwdata[1:0]) &&
                line_transmit_enable == $past(hwdata[1])))
    else $error("direction write not captured");

  a_dir_hold_other: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !dir_wr |=> $stable(dir_q))
    else $error("direction changed without a direction write");

  a_uart_no_dir: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (take && hreadyout && haddr[31:12] == rsp_pkg::IO_PAGE &&
     haddr[11:5] == win_base[9:3] && haddr[4:2] == rsp_pkg::DIR_OFS) |=>
    (!ureq.wr && !ureq.rd && (dir_wr || !wr_q)))
    else $error("serial controller reached at offset seven");

  a_drive_follows: assert property (
    @(posedge hclk) disable iff (!hresetn)
    line_oe_n == !dir_q[rsp_pkg::DIR_TX] &&
    line_receive_enable == dir_q[rsp_pkg::DIR_RX])
    else $error("line driver does not follow direction");

  a_rx_gate_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !dir_q[rsp_pkg::DIR_RX] |-> rxd_int)
    else $error("receiver hears line while disabled");

  a_echo_both: assert property (
    @(posedge hclk) disable iff (!hresetn)
    dir_q == rsp_pkg::DIR_BOTH |-> rxd_int == uart_txd)
    else $error("echo missing with both directions on");

  a_base_com2: assert property (
    @(posedge hclk) disable iff (!hresetn)
    sw_s2_q == rsp_pkg::SW_COM2 |-> win_base == rsp_pkg::BASE_COM2)
    else $error("switch 8 up does not give second base");

  a_base_com1: assert property (
    @(posedge hclk) disable iff (!hresetn)
    sw_s2_q == rsp_pkg::SW_COM1 |-> win_base == rsp_pkg::BASE_COM1)
    else $error("all switches down does not give first base");

  a_base_com34: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (sw_s2_q == rsp_pkg::SW_COM3 |-> win_base == rsp_pkg::BASE_COM3) and
    (sw_s2_q == rsp_pkg::SW_COM4 |-> win_base == rsp_pkg::BASE_COM4))
    else $error("switch 4 settings give wrong base");

  a_window_only: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (take && st_q == rsp_pkg::ST_IDLE &&
     haddr[11:5] != win_base[9:3]) |=>
    (tgt_q != rsp_pkg::T_UART && tgt_q != rsp_pkg::T_DIR))
    else $error("access outside window was decoded");

  a_irq_route: assert property (
    @(posedge hclk) disable iff (!hresetn)
    uart_intr |=> (irq_level4 == !$past(jmp_s2_q) &&
                   irq_level3 == $past(jmp_s2_q)))
    else $error("interrupt sent to wrong level");

  a_one_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (take && hreadyout) |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after exactly one wait state");

  a_uart_strobe: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (take && hreadyout && haddr[31:12] == rsp_pkg::IO_PAGE &&
     haddr[11:5] == win_base[9:3] && haddr[4:2] != rsp_pkg::DIR_OFS) |=>
    (ureq.wr || ureq.rd))
    else $error("window offset zero to six not passed on");

  a_half_duplex: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (line_oe_n && !line_receive_enable) |-> rxd_int)
    else $error("idle line not seen as idle");

  a_status_irq: assert property (
    @(posedge hclk) disable iff (!hresetn)
    |(stat_q & mask_q) |=> irq)
    else $error("unmasked status did not raise interrupt");

  a_status_keep: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (|events) |=> ((stat_q & $past(events)) == $past(events)))
    else $error("status event lost or not latched");

endmodule : rsp_top

/* verification/rsp_remote.sv */
`timescale 1ns/1ps
module rsp_remote #(
  parameter int BIT_CYC = 16
) (
  input wire logic hclk,
  input wire logic line_out,
  input wire logic line_oe_n,
  output logic line_in,
  output logic [7:0] got_byte,
  output int got_n
);
  logic drv = 1'b1;
  logic busy = 1'b0;
  logic wire_lvl;
  // Fail-safe bias holds an undriven pair at the mark level
  assign wire_lvl = line_oe_n ? drv : line_out;
  assign line_in = wire_lvl;
  initial got_n = 0;
  // The remote never listens to its own frame, unlike the controller with both directions on
  initial begin
    forever begin
      @(negedge wire_lvl);
      if (!busy) begin
        repeat (BIT_CYC / 2) @(posedge hclk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge hclk);
          got_byte[i] = wire_lvl;
        end
        got_n++;
      end
    end
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    busy = 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(posedge hclk);
      drv <= f[i];
      repeat (BIT_CYC - 1) @(posedge hclk);
    end
    @(posedge hclk);
    busy = 1'b0;
  endtask : send
endmodule : rsp_remote

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans, dir_exp;
  logic [2:0] hsize;
  logic [6:0] base_switch_up;
  logic irq_jumper, line_in, line_out, line_oe_n, irq;
  logic line_transmit_enable, line_receive_enable, irq_level4, irq_level3;
  logic [7:0] got_byte;
  logic [9:0] base;
  int got_n, cnt, mismatches = 0, n_compared = 0, cycles = 0;
  assign hready = hreadyout;
  rsp_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .base_switch_up(base_switch_up),
    .irq_jumper(irq_jumper), .line_in(line_in), .line_out(line_out),
    .line_oe_n(line_oe_n), .line_transmit_enable(line_transmit_enable),
    .line_receive_enable(line_receive_enable), .irq_level4(irq_level4),
    .irq_level3(irq_level3), .irq(irq)
  );
  rsp_remote remote (
    .hclk(hclk), .line_out(line_out), .line_oe_n(line_oe_n),
    .line_in(line_in), .got_byte(got_byte), .got_n(got_n)
  );
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      $display("ERROR at %0t: run did not finish", $time);
      results();
    end
  end
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rv = hrdata;
    check(hresp, 1'b0);
  endtask : ahb
  // I/O address times four is the byte address on the bus
  function automatic logic [31:0] io(input logic [9:0] b,
                                     input logic [2:0] ofs);
    return {20'h00000, b[9:3], ofs, 2'b00};
  endfunction : io
  task automatic uw(input logic [2:0] ofs, input logic [7:0] b);
    ahb(1'b1, io(base, ofs), {24'h000000, b});
  endtask : uw
  task automatic ur(input logic [2:0] ofs);
    ahb(1'b0, io(base, ofs), 32'h0);
  endtask : ur
  task automatic set_dir(input logic [1:0] d);
    uw(3'h7, {6'h00, d});
    dir_exp = d;
  endtask : set_dir
  task automatic chk_dir;
    check(line_receive_enable, dir_exp[0]);
    check(line_transmit_enable, dir_exp[1]);
    check(line_oe_n, !dir_exp[1]);
  endtask : chk_dir
  // Polls the line status until a byte is ready; bounded by the poll count
  task automatic wait_dr;
    for (int i = 0; i < 200; i++) begin
      ur(3'h5);
      if (rv[0] === 1'b1) break;
    end
  endtask : wait_dr
  task automatic t_reset;
    chk_dir;
    check(irq, 1'b0);
    check(hreadyout, 1'b1);
    repeat (3) @(posedge hclk);
  endtask : t_reset
  task automatic t_decode;
    logic [6:0] sw [4];
    logic [9:0] bs [4];
    sw = '{7'h00, 7'h20, 7'h02, 7'h22};
    bs = '{10'h3F8, 10'h2F8, 10'h3E8, 10'h2E8};
    for (int i = 0; i < 4; i++) begin
      base_switch_up <= sw[i];
      repeat (4) @(posedge hclk);
      ahb(1'b1, io(bs[(i + 1) % 4], 3'h7), 32'h00000003);
      chk_dir;
      base = bs[i];
      ahb(1'b1, io(base, 3'h7), 32'h000000FC | 32'(i));
      dir_exp = 2'(i);
      chk_dir;
      ur(3'h7);
      check(rv, 32'h0);
    end
  endtask : t_decode
  task automatic t_keep;
    set_dir(2'h3);
    uw(3'h3, 8'h80);
    uw(3'h0, 8'h01);
    uw(3'h1, 8'h00);
    uw(3'h3, 8'h03);
    uw(3'h1, 8'h00);
    uw(3'h4, 8'h00);
    uw(3'h2, 8'h00);
    ur(3'h5);
    check(rv, 32'h60);
    ur(3'h2);
    check(rv, 32'h01);
    chk_dir;
  endtask : t_keep
  task automatic t_echo;
    cnt = got_n;
    uw(3'h0, 8'h55);
    wait_dr;
    check(rv[0], 1'b1);
    ur(3'h0);
    check(rv, 32'h55);
    check(got_n, cnt + 1);
    check(got_byte, 8'h55);
  endtask : t_echo
  task automatic t_receive;
    ahb(1'b1, 32'h00001004, 32'h1);
    ahb(1'b0, 32'h00001004, 32'h0);
    check(rv, 32'h1);
    ahb(1'b0, 32'h00001000, 32'h0);
    uw(3'h1, 8'h01);
    uw(3'h4, 8'h08);
    set_dir(2'h1);
    chk_dir;
    irq_jumper <= 1'b0;
    repeat (4) @(posedge hclk);
    check(irq, 1'b0);
    fork
      remote.send(8'hA6);
    join_none
    wait_dr;
    check(rv[0], 1'b1);
    repeat (2) @(posedge hclk);
    check(irq_level4, 1'b1);
    check(irq_level3, 1'b0);
    check(irq, 1'b1);
    irq_jumper <= 1'b1;
    repeat (4) @(posedge hclk);
    check(irq_level3, 1'b1);
    check(irq_level4, 1'b0);
    ahb(1'b0, 32'h00001000, 32'h0);
    check(rv[0], 1'b1);
    check(rv[2], 1'b1);
    repeat (2) @(posedge hclk);
    check(irq, 1'b0);
    ur(3'h0);
    check(rv, 32'hA6);
    repeat (2) @(posedge hclk);
    check(irq_level3, 1'b0);
  endtask : t_receive
  task automatic t_transmit;
    set_dir(2'h2);
    chk_dir;
    cnt = got_n;
    uw(3'h0, 8'h3C);
    for (int i = 0; i < 400 && got_n == cnt; i++) @(posedge hclk);
    check(got_n, cnt + 1);
    check(got_byte, 8'h3C);
    set_dir(2'h0);
    chk_dir;
    remote.send(8'h11);
    repeat (20) @(posedge hclk);
    ur(3'h5);
    check(rv[0], 1'b0);
  endtask : t_transmit
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    base_switch_up = 7'h00;
    irq_jumper = 1'b0;
    base = 10'h3F8;
    dir_exp = 2'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_decode;
    t_keep;
    t_echo;
    t_receive;
    t_transmit;
    results();
  end
endmodule : testbench
